/* File: hw/dcid_pkg.sv */
// constants for the two-processor interrupt delivery core
// assumes one 10 MHz clock and a register window of 256KB seen through an 18-bit byte address
package dcid_pkg;
	// source population: ids 0..15 external, 16 error, 17..20 interprocessor, 21..24 timer
	localparam int NCPU      = 2;
	localparam int NEXT      = 16;
	localparam int NDIST     = 17;
	localparam int NINT      = 4;
	localparam int NSRC      = 25;
	localparam int IPI_BASE  = 17;
	localparam int TMR_BASE  = 21;
	localparam int PRIO_W    = 4;
	localparam int ID_W      = 5;
	localparam int VEC_W     = 8;
	localparam int NLVL      = 15;
	localparam int ISR_W     = 40;
	localparam int ISR_ID_LSB = 15;
	localparam int ADDR_W    = 18;
	localparam int DATA_W    = 32;

	// per-source configuration word fields
	localparam int CFG_VEC_LSB   = 0;
	localparam int CFG_PRIO_LSB  = 16;
	localparam int CFG_POL_BIT   = 22;
	localparam int CFG_SENSE_BIT = 23;
	localparam int CFG_DEST_LSB  = 24;
	localparam int CFG_ACT_BIT   = 30;
	localparam int CFG_MASK_BIT  = 31;
	localparam logic [31:0] CFG_RW_MASK = 32'h83cf00ff;
	localparam logic [31:0] CFG_RST     = 32'h80000000;

	// register offsets; bit CPU_SEL_BIT picks processor 1 for per-processor registers
	localparam int CFG_SPAN_LSB = 7;
	localparam int CPU_SEL_BIT  = 12;
	localparam logic [ADDR_W-1:0] CFG_BASE = 18'h10000;
	localparam logic [ADDR_W-1:0] SPUR_OFF = 18'h010e0;
	localparam logic [ADDR_W-1:0] PCLR_OFF = 18'h20010;
	localparam logic [ADDR_W-1:0] DISP_OFF = 18'h20040;
	localparam logic [ADDR_W-1:0] TASK_OFF = 18'h20080;
	localparam logic [ADDR_W-1:0] IACK_OFF = 18'h200a0;
	localparam logic [ADDR_W-1:0] EOI_OFF  = 18'h200b0;

	localparam logic [VEC_W-1:0]  SPUR_RST = 8'hff;
	localparam logic [PRIO_W-1:0] TASK_RST = 4'hf;
	localparam logic [PRIO_W-1:0] PRIO_OFF = 4'h0;
endpackage

/* File: hw/dcid_core.sv */
// two-processor interrupt delivery core: pending stage, selectors, held requests, in-service sets, router
// assumes synchronous request pins, timer events as one-cycle pulses, and a simple no-wait register port
`timescale 1ns/10ps

module dcid_core #(
	parameter int NEXT_P = dcid_pkg::NEXT
) (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// register port
	input  wire logic [dcid_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [dcid_pkg::DATA_W-1:0]  wr_data_i,
	input  wire logic [3:0]                   wr_be_i,
	input  wire logic                         wr_i,
	input  wire logic                         rd_i,
	output logic      [dcid_pkg::DATA_W-1:0]  rd_data_o,
	// interrupt sources
	input  wire logic [NEXT_P-1:0]            ext_irq_i,
	input  wire logic                         err_irq_i,
	input  wire logic [dcid_pkg::NINT-1:0]    timer_evt_i,
	// processor interrupt pins
	output logic      [dcid_pkg::NCPU-1:0]    cpu_int_o
);
	localparam int NCPU  = dcid_pkg::NCPU;
	localparam int NSRC  = dcid_pkg::NSRC;
	localparam int NDIST = dcid_pkg::NDIST;
	localparam int NINT  = dcid_pkg::NINT;
	localparam int PW    = dcid_pkg::PRIO_W;
	localparam int IW    = dcid_pkg::ID_W;
	localparam int VW    = dcid_pkg::VEC_W;
	localparam int DW    = dcid_pkg::DATA_W;
	localparam int AW    = dcid_pkg::ADDR_W;
	localparam int IPI_BASE_I = dcid_pkg::IPI_BASE;

	// registers
	logic [DW-1:0]        cfg_q      [NSRC];
	logic [DW-1:0]        cfg_d      [NSRC];
	logic [PW-1:0]        task_q     [NCPU];
	logic [PW-1:0]        task_d     [NCPU];
	logic [VW-1:0]        spur_q;
	logic [VW-1:0]        spur_d;
	logic [NDIST-1:0]     in_q;
	logic [NDIST-1:0]     in_prev_q;
	logic [NDIST-1:0]     pend_q;
	logic [NDIST-1:0]     pend_d;
	logic [2*NINT-1:0]    ipend_q    [NCPU];
	logic [2*NINT-1:0]    ipend_d    [NCPU];
	logic [NCPU-1:0]      sel_v_q;
	logic [PW-1:0]        sel_p_q    [NCPU];
	logic [IW-1:0]        sel_id_q   [NCPU];
	logic [NCPU-1:0]      hold_v_q;
	logic [NCPU-1:0]      hold_v_d;
	logic [PW-1:0]        hold_p_q   [NCPU];
	logic [PW-1:0]        hold_p_d   [NCPU];
	logic [IW-1:0]        hold_id_q  [NCPU];
	logic [IW-1:0]        hold_id_d  [NCPU];
	logic [dcid_pkg::ISR_W-1:0] isr_q [NCPU];
	logic [dcid_pkg::ISR_W-1:0] isr_d [NCPU];
	logic [NCPU-1:0]      int_q;
	logic [NCPU-1:0]      int_d;
	logic [DW-1:0]        rd_data_q;
	logic [DW-1:0]        rd_data_d;

	// combinational
	logic [NDIST-1:0]     act_lvl;
	logic [NDIST-1:0]     pend_out;
	logic [NSRC-1:0]      req        [NCPU];
	logic [NCPU-1:0]      sel_v_d;
	logic [PW-1:0]        sel_p_d    [NCPU];
	logic [IW-1:0]        sel_id_d   [NCPU];
	logic [PW-1:0]        isr_top    [NCPU];
	logic [IW-1:0]        eoi_id     [NCPU];
	logic [NCPU-1:0]      ack;
	logic [NCPU-1:0]      ack_ok;
	logic [NCPU-1:0]      end_of_interrupt;
	logic [NCPU-1:0]      tsk_wr;
	logic [NSRC-1:0]      acked      [NCPU];
	logic [AW-1:0]        addr_pc;
	logic [AW-1:0]        addr_w;
	logic                 addr_cpu;
	logic                 cfg_hit;
	logic [IW-1:0]        cfg_idx;
	logic [DW-1:0]        bmask;
	logic [NSRC-1:0]      src_act;

	// address split: per-processor registers differ only in one address bit
	always_comb begin
		// lanes inside one word reach the same register, so narrow accesses decode alike
		addr_w = {addr_i[AW-1:2], 2'b00};
		addr_pc = addr_w;
		addr_pc[dcid_pkg::CPU_SEL_BIT] = 1'b0;
		addr_cpu = addr_i[dcid_pkg::CPU_SEL_BIT];
		cfg_idx = addr_i[dcid_pkg::CFG_SPAN_LSB-1:2];
		cfg_hit = (addr_i[AW-1:dcid_pkg::CFG_SPAN_LSB] == dcid_pkg::CFG_BASE[AW-1:dcid_pkg::CFG_SPAN_LSB])
			&& (cfg_idx < IW'(NSRC));
		bmask = {{8{wr_be_i[3]}}, {8{wr_be_i[2]}}, {8{wr_be_i[1]}}, {8{wr_be_i[0]}}};
		for (int c = 0; c < NCPU; c++) begin
			ack[c]    = rd_i && addr_pc == dcid_pkg::IACK_OFF && addr_cpu == c[0];
			end_of_interrupt[c]    = wr_i && addr_pc == dcid_pkg::EOI_OFF && addr_cpu == c[0];
			tsk_wr[c] = wr_i && wr_be_i[0] && addr_pc == dcid_pkg::TASK_OFF && addr_cpu == c[0];
		end
	end

	// pending stage outputs and per-processor qualification
	always_comb begin
		for (int i = 0; i < NDIST; i++) begin
			act_lvl[i] = cfg_q[i][dcid_pkg::CFG_POL_BIT] ? in_q[i] : ~in_q[i];
			pend_out[i] = cfg_q[i][dcid_pkg::CFG_SENSE_BIT] ? act_lvl[i] : pend_q[i];
		end
		for (int c = 0; c < NCPU; c++) begin
			for (int i = 0; i < NSRC; i++) begin
				if (i < NDIST) begin
					req[c][i] = pend_out[i] && cfg_q[i][dcid_pkg::CFG_DEST_LSB+c];
				end else begin
					req[c][i] = ipend_q[c][i-NDIST];
				end
				req[c][i] = req[c][i] && !cfg_q[i][dcid_pkg::CFG_MASK_BIT]
					&& cfg_q[i][dcid_pkg::CFG_PRIO_LSB+:PW] != dcid_pkg::PRIO_OFF;
			end
		end
	end

	// selector: highest priority qualified request, lowest id on a tie
	// both selectors see a shared external request; the router lets only one pin rise for it
	always_comb begin
		for (int c = 0; c < NCPU; c++) begin
			sel_v_d[c] = 1'b0;
			sel_p_d[c] = '0;
			sel_id_d[c] = '0;
			for (int i = 0; i < NSRC; i++) begin
				if (req[c][i] && (!sel_v_d[c] || cfg_q[i][dcid_pkg::CFG_PRIO_LSB+:PW] > sel_p_d[c])) begin
					sel_v_d[c] = 1'b1;
					sel_p_d[c] = cfg_q[i][dcid_pkg::CFG_PRIO_LSB+:PW];
					sel_id_d[c] = IW'(i);
				end
			end
		end
	end

	// held request, acknowledge and in-service bookkeeping
	always_comb begin
		for (int c = 0; c < NCPU; c++) begin
			hold_v_d[c] = ack[c] ? hold_v_q[c] : sel_v_q[c];
			hold_p_d[c] = ack[c] ? hold_p_q[c] : sel_p_q[c];
			hold_id_d[c] = ack[c] ? hold_id_q[c] : sel_id_q[c];
			// a request that vanished or got masked before the ack gets the spurious vector
			ack_ok[c] = ack[c] && hold_v_q[c] && req[c][hold_id_q[c]];
			acked[c] = '0;
			if (ack_ok[c]) begin
				acked[c][hold_id_q[c]] = 1'b1;
			end
			isr_top[c] = '0;
			for (int l = 1; l <= dcid_pkg::NLVL; l++) begin
				if (isr_q[c][l-1]) begin
					isr_top[c] = PW'(l);
				end
			end
			// end-of-interrupt target: the in-service source at the top level
			eoi_id[c] = '0;
			for (int i = 0; i < NSRC; i++) begin
				if (isr_q[c][dcid_pkg::ISR_ID_LSB+i] && cfg_q[i][dcid_pkg::CFG_PRIO_LSB+:PW] == isr_top[c]) begin
					eoi_id[c] = IW'(i);
				end
			end
			// an end-of-interrupt with nothing in service changes nothing
			isr_d[c] = isr_q[c];
			if (ack_ok[c]) begin
				isr_d[c][hold_p_q[c]-PW'(1)] = 1'b1;
				isr_d[c][dcid_pkg::ISR_ID_LSB+int'(hold_id_q[c])] = 1'b1;
			end else if (end_of_interrupt[c] && isr_top[c] != dcid_pkg::PRIO_OFF) begin
				isr_d[c][isr_top[c]-PW'(1)] = 1'b0;
				isr_d[c][dcid_pkg::ISR_ID_LSB+int'(eoi_id[c])] = 1'b0;
			end
		end
	end

	// pending latches: capture wins over clear in the same cycle
	always_comb begin
		for (int i = 0; i < NDIST; i++) begin
			pend_d[i] = pend_q[i];
			if (acked[0][i] || acked[1][i]) begin
				pend_d[i] = 1'b0;
			end
			if (wr_i && wr_be_i[i/8] && addr_w == dcid_pkg::PCLR_OFF && wr_data_i[i]) begin
				pend_d[i] = 1'b0;
			end
			if (act_lvl[i] && !(cfg_q[i][dcid_pkg::CFG_POL_BIT] ? in_prev_q[i] : ~in_prev_q[i])) begin
				pend_d[i] = 1'b1;
			end
		end
		for (int c = 0; c < NCPU; c++) begin
			for (int k = 0; k < 2*NINT; k++) begin
				ipend_d[c][k] = ipend_q[c][k] && !acked[c][IPI_BASE_I+k];
				if (cfg_q[IPI_BASE_I+k][dcid_pkg::CFG_DEST_LSB+c]) begin
					if (k < NINT) begin
						if (wr_i && wr_be_i[0] && addr_w == dcid_pkg::DISP_OFF && wr_data_i[k]) begin
							ipend_d[c][k] = 1'b1;
						end
					end else if (timer_evt_i[k-NINT]) begin
						ipend_d[c][k] = 1'b1;
					end
				end
			end
		end
	end

	// router
	always_comb begin
		for (int c = 0; c < NCPU; c++) begin
			logic ext;
			logic other_dest;
			logic in_other;
			logic wins_task;
			ext = hold_id_q[c] < IW'(NDIST);
			other_dest = cfg_q[hold_id_q[c]][dcid_pkg::CFG_DEST_LSB+1-c];
			in_other = isr_q[1-c][dcid_pkg::ISR_ID_LSB+int'(hold_id_q[c])];
			// processor 0 takes the tie
			wins_task = (c == 0) ? (task_q[0] <= task_q[1]) : (task_q[1] < task_q[0]);
			int_d[c] = hold_v_q[c]
				&& hold_p_q[c] > isr_top[c] && hold_p_q[c] > task_q[c]
				&& (!ext
					|| !other_dest
					|| (!in_other && wins_task));
		end
	end

	// register writes and read answer
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			cfg_d[i] = cfg_q[i];
			src_act[i] = isr_q[0][dcid_pkg::ISR_ID_LSB+i] || isr_q[1][dcid_pkg::ISR_ID_LSB+i]
				|| (i < NDIST ? pend_out[i] : (ipend_q[0][i-NDIST] || ipend_q[1][i-NDIST]));
		end
		if (wr_i && cfg_hit) begin
			cfg_d[cfg_idx] = (cfg_q[cfg_idx] & ~(bmask & dcid_pkg::CFG_RW_MASK))
				| (wr_data_i & bmask & dcid_pkg::CFG_RW_MASK);
		end
		spur_d = spur_q;
		if (wr_i && wr_be_i[0] && addr_w == dcid_pkg::SPUR_OFF) begin
			spur_d = wr_data_i[VW-1:0];
		end
		for (int c = 0; c < NCPU; c++) begin
			task_d[c] = tsk_wr[c] ? wr_data_i[PW-1:0] : task_q[c];
		end
	end

	// read answer: stands one cycle after the strobe, zero otherwise
	always_comb begin
		rd_data_d = '0;
		if (rd_i) begin
			if (cfg_hit) begin
				rd_data_d = cfg_q[cfg_idx] & dcid_pkg::CFG_RW_MASK;
				rd_data_d[dcid_pkg::CFG_ACT_BIT] = src_act[cfg_idx];
			end else if (addr_pc == dcid_pkg::TASK_OFF) begin
				rd_data_d[PW-1:0] = task_q[addr_cpu];
			end else if (addr_pc == dcid_pkg::IACK_OFF) begin
				rd_data_d[VW-1:0] = ack_ok[addr_cpu] ? cfg_q[hold_id_q[addr_cpu]][dcid_pkg::CFG_VEC_LSB+:VW] : spur_q;
			end else if (addr_w == dcid_pkg::SPUR_OFF) begin
				rd_data_d[VW-1:0] = spur_q;
			end
		end
	end

	// configuration, task priorities and spurious vector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NSRC; i++) begin
				cfg_q[i] <= dcid_pkg::CFG_RST;
			end
			for (int c = 0; c < NCPU; c++) begin
				task_q[c] <= dcid_pkg::TASK_RST;
			end
			spur_q <= dcid_pkg::SPUR_RST;
		end else begin
			cfg_q  <= cfg_d;
			task_q <= task_d;
			spur_q <= spur_d;
		end
	end

	// pending stage: sampled inputs, edge history and latches
	// edge history resets equal to the sampled inputs, so reset never looks like an edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_q      <= '0;
			in_prev_q <= '0;
			pend_q    <= '0;
			for (int c = 0; c < NCPU; c++) begin
				ipend_q[c] <= '0;
			end
		end else begin
			in_q      <= NDIST'({err_irq_i, ext_irq_i});
			in_prev_q <= in_q;
			pend_q    <= pend_d;
			ipend_q   <= ipend_d;
		end
	end

	// selector pipeline and held request
	// the held copy is what an acknowledge returns, so it must not move under the read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_v_q  <= '0;
			hold_v_q <= '0;
			for (int c = 0; c < NCPU; c++) begin
				sel_p_q[c]   <= '0;
				sel_id_q[c]  <= '0;
				hold_p_q[c]  <= '0;
				hold_id_q[c] <= '0;
			end
		end else begin
			sel_v_q   <= sel_v_d;
			sel_p_q   <= sel_p_d;
			sel_id_q  <= sel_id_d;
			hold_v_q  <= hold_v_d;
			hold_p_q  <= hold_p_d;
			hold_id_q <= hold_id_d;
		end
	end

	// in-service sets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < NCPU; c++) begin
				isr_q[c] <= '0;
			end
		end else begin
			isr_q <= isr_d;
		end
	end

	// pins and read answer, both straight from flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_q     <= '0;
			rd_data_q <= '0;
		end else begin
			int_q     <= int_d;
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data_o = rd_data_q;
	assign cpu_int_o = int_q;
endmodule

/* File: sim/dcid_core_properties.sv */
// port-level assertions for the delivery core
// assumes binding onto dcid_core; task priorities are shadowed from register writes
`timescale 1ns/10ps
module dcid_core_chk (
	// watched ports
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	input wire logic [dcid_pkg::ADDR_W-1:0] addr_i,
	input wire logic [dcid_pkg::DATA_W-1:0] wr_data_i,
	input wire logic [3:0]                  wr_be_i,
	input wire logic                        wr_i,
	input wire logic                        rd_i,
	input wire logic [dcid_pkg::DATA_W-1:0] rd_data_o,
	input wire logic [dcid_pkg::NCPU-1:0]   cpu_int_o
);
	logic [3:0] task0_q;
	logic [3:0] task0_d;
	logic [3:0] task1_q;
	logic [3:0] task1_d;
	logic       tw0;
	logic       tw1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign tw0 = wr_i && wr_be_i[0] && (addr_i & ~18'h00003) == dcid_pkg::TASK_OFF;
	assign tw1 = wr_i && wr_be_i[0] && (addr_i & ~18'h00003) == (dcid_pkg::TASK_OFF | 18'h01000);
	always_comb begin
		task0_d = tw0 ? wr_data_i[3:0] : task0_q;
		task1_d = tw1 ? wr_data_i[3:0] : task1_q;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			task0_q <= dcid_pkg::TASK_RST;
			task1_q <= dcid_pkg::TASK_RST;
		end else begin
			task0_q <= task0_d;
			task1_q <= task1_d;
		end
	end
	a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == '0)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (rd_i && addr_i[17:16] == 2'b11 |=> rd_data_o == '0)
		else $error("unmapped read not zero");
	a_eoi_reads_zero: assert property (rd_i && (addr_i & ~18'h01003) == dcid_pkg::EOI_OFF |=> rd_data_o == '0)
		else $error("end of interrupt read not zero");
	a_task_readback: assert property (rd_i && (addr_i & ~18'h00003) == dcid_pkg::TASK_OFF
		|=> rd_data_o == {28'h0, $past(task0_q)})
		else $error("task priority read back wrong");
	a_reset_quiet: assert property ($fell(rst_i) |-> (cpu_int_o == 2'b00) [*4])
		else $error("pin active right after reset");
	a_task_block0: assert property ((task0_q == 4'hf) [*4] |-> !cpu_int_o[0])
		else $error("processor 0 pin active at task priority 15");
	a_task_block1: assert property ((task1_q == 4'hf) [*4] |-> !cpu_int_o[1])
		else $error("processor 1 pin active at task priority 15");
	a_ack_drops0: assert property (rd_i && addr_i == dcid_pkg::IACK_OFF && cpu_int_o[0] |-> ##[1:4] !cpu_int_o[0])
		else $error("processor 0 pin held after acknowledge");
	a_ack_drops1: assert property (rd_i && addr_i == (dcid_pkg::IACK_OFF | 18'h01000) && cpu_int_o[1]
		|-> ##[1:4] !cpu_int_o[1])
		else $error("processor 1 pin held after acknowledge");
	c_pin0: cover property ($rose(cpu_int_o[0]));
	c_pin1: cover property ($rose(cpu_int_o[1]));
	c_both: cover property (cpu_int_o == 2'b11);
endmodule

bind dcid_core dcid_core_chk dcid_core_chk_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
	.wr_be_i(wr_be_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .cpu_int_o(cpu_int_o));

/* File: sim/dcid_cpu_model.sv */
// two processors as register-port masters: writes, reads, acknowledges, end of interrupt
// assumes the no-wait register port of dcid_core
`timescale 1ns/10ps
module dcid_cpu_model (
	// clock
	input  wire logic                        clk_i,
	// register port toward the core
	output logic      [dcid_pkg::ADDR_W-1:0] addr_o,
	output logic      [dcid_pkg::DATA_W-1:0] wr_data_o,
	output logic      [3:0]                  wr_be_o,
	output logic                             wr_o,
	output logic                             rd_o,
	input  wire logic [dcid_pkg::DATA_W-1:0] rd_data_i
);
	initial begin
		addr_o = '0;
		wr_data_o = '0;
		wr_be_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr_reg(input logic [17:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_i);
		addr_o <= a;
		wr_data_o <= d;
		wr_be_o <= be;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wr_data_o <= ~d;
	endtask
	task automatic rd_reg(input logic [17:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(negedge clk_i);
		d = rd_data_i;
	endtask
	// processor c takes its interrupt after slow idle cycles
	task automatic ack(input int c, input int slow, output logic [31:0] v);
		repeat (slow) @(posedge clk_i);
		rd_reg(dcid_pkg::IACK_OFF | (c ? 18'h01000 : 18'h0), v);
	endtask
	task automatic end_of_interrupt(input int c);
		wr_reg(dcid_pkg::EOI_OFF | (c ? 18'h01000 : 18'h0), 32'h0, 4'hf);
	endtask
endmodule

/* File: sim/dcid_core_test.sv */
// self-checking bench for the delivery core
// assumes dcid_core_chk is bound and dcid_cpu_model drives the register port
`timescale 1ns/10ps
module dcid_core_test;
	logic        clk_i;
	logic        rst_i;
	logic [17:0] addr;
	logic [31:0] wr_data;
	logic [31:0] rd_data;
	logic [3:0]  wr_be;
	logic        wr;
	logic        rd;
	logic [15:0] ext_irq;
	logic [3:0]  timer_evt;
	logic        err_irq;
	logic [1:0]  cpu_int;
	logic [31:0] v;
	int          miscompares;
	int          n_compared;

	always #50 clk_i = ~clk_i;
	dcid_core dcid_core_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wr_data), .wr_be_i(wr_be),
		.wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .ext_irq_i(ext_irq), .err_irq_i(err_irq),
		.timer_evt_i(timer_evt), .cpu_int_o(cpu_int));
	dcid_cpu_model dcid_cpu_model_i (.clk_i(clk_i), .addr_o(addr), .wr_data_o(wr_data), .wr_be_o(wr_be),
		.wr_o(wr), .rd_o(rd), .rd_data_i(rd_data));

	task automatic finish_test();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pin(input int c, input logic val);
		int i;
		@(negedge clk_i);
		for (i = 0; i < 30 && cpu_int[c] !== val; i++)
			@(negedge clk_i);
		chk({31'h0, cpu_int[c]}, {31'h0, val});
		if (cpu_int[c] !== val)
			finish_test();
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge clk_i);
			chk({30'h0, cpu_int}, 32'h0);
		end
	endtask
	task automatic w(input logic [17:0] a, input logic [31:0] d);
		dcid_cpu_model_i.wr_reg(a, d, 4'hf);
	endtask
	task automatic tasks(input logic [3:0] t0, input logic [3:0] t1);
		w(dcid_pkg::TASK_OFF, {28'h0, t0});
		w(dcid_pkg::TASK_OFF | 18'h01000, {28'h0, t1});
	endtask
	task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
		dcid_cpu_model_i.rd_reg(a, v);
		chk(v, exp);
	endtask
	task automatic pulse(input int i);
		@(posedge clk_i) ext_irq[i] <= 1'b1;
		@(posedge clk_i) ext_irq[i] <= 1'b0;
	endtask
	function automatic logic [17:0] cfg(input int id);
		return dcid_pkg::CFG_BASE + 18'(4 * id);
	endfunction
	// sl is sense then polarity, dst is processor 1 then processor 0
	function automatic logic [31:0] cw(input logic [7:0] vec, input logic [3:0] pr, input logic [1:0] sl,
		input logic [1:0] dst);
		return {6'h0, dst, sl, 2'h0, pr, 8'h0, vec};
	endfunction

	task automatic s_regs();
		rd_chk(dcid_pkg::SPUR_OFF, 32'h000000ff);
		rd_chk(cfg(0), 32'h80000000);
		rd_chk(dcid_pkg::TASK_OFF, 32'h0000000f);
		rd_chk(18'h30040, 32'h0);
		rd_chk(dcid_pkg::EOI_OFF, 32'h0);
		dcid_cpu_model_i.wr_reg(dcid_pkg::TASK_OFF, 32'hffffff05, 4'h1);
		rd_chk(dcid_pkg::TASK_OFF, 32'h00000005);
		dcid_cpu_model_i.wr_reg(cfg(1), 32'hffffffff, 4'hc);
		rd_chk(cfg(1), 32'h83cf0000);
	endtask
	task automatic s_edge();
		tasks(4'h0, 4'h0);
		w(cfg(3), cw(8'h33, 4'h5, 2'b01, 2'b01));
		w(cfg(4), cw(8'h34, 4'h5, 2'b01, 2'b01));
		pulse(3);
		pin(0, 1'b1);
		chk({30'h0, cpu_int}, 32'h1);
		dcid_cpu_model_i.ack(0, 2, v);
		chk(v, 32'h33);
		pin(0, 1'b0);
		pulse(4);
		quiet(10);
		dcid_cpu_model_i.end_of_interrupt(0);
		pin(0, 1'b1);
		dcid_cpu_model_i.ack(0, 0, v);
		chk(v, 32'h34);
		pin(0, 1'b0);
		rd_chk(dcid_pkg::IACK_OFF, 32'hff);
		dcid_cpu_model_i.end_of_interrupt(0);
	endtask
	task automatic s_shared();
		w(cfg(5), cw(8'h55, 4'h7, 2'b11, 2'b11));
		tasks(4'h3, 4'h1);
		@(posedge clk_i) ext_irq[5] <= 1'b1;
		pin(1, 1'b1);
		chk({30'h0, cpu_int}, 32'h2);
		w(dcid_pkg::TASK_OFF | 18'h01000, 32'h3);
		pin(0, 1'b1);
		pin(1, 1'b0);
		w(dcid_pkg::TASK_OFF, 32'hf);
		pin(0, 1'b0);
		pin(1, 1'b1);
		@(posedge clk_i) ext_irq[5] <= 1'b0;
		pin(1, 1'b0);
	endtask
	task automatic s_direct();
		tasks(4'h0, 4'h0);
		w(cfg(17), cw(8'h17, 4'h6, 2'b00, 2'b11));
		w(dcid_pkg::DISP_OFF, 32'h1);
		pin(0, 1'b1);
		pin(1, 1'b1);
		dcid_cpu_model_i.ack(0, 0, v);
		chk(v, 32'h17);
		pin(0, 1'b0);
		chk({30'h0, cpu_int}, 32'h2);
		dcid_cpu_model_i.ack(1, 3, v);
		chk(v, 32'h17);
		dcid_cpu_model_i.end_of_interrupt(0);
		dcid_cpu_model_i.end_of_interrupt(1);
		w(cfg(21), cw(8'h21, 4'h9, 2'b00, 2'b10));
		@(posedge clk_i) timer_evt[0] <= 1'b1;
		@(posedge clk_i) timer_evt[0] <= 1'b0;
		pin(1, 1'b1);
		chk({30'h0, cpu_int}, 32'h2);
		dcid_cpu_model_i.ack(1, 0, v);
		chk(v, 32'h21);
		dcid_cpu_model_i.end_of_interrupt(1);
	endtask
	task automatic s_mask();
		tasks(4'h0, 4'h0);
		w(cfg(2), cw(8'h02, 4'h0, 2'b01, 2'b01));
		pulse(2);
		quiet(10);
		w(cfg(2), cw(8'h02, 4'h4, 2'b01, 2'b01) | 32'h80000000);
		quiet(10);
		w(cfg(2), cw(8'h02, 4'h4, 2'b01, 2'b01));
		pin(0, 1'b1);
		dcid_cpu_model_i.ack(0, 1, v);
		chk(v, 32'h02);
		dcid_cpu_model_i.end_of_interrupt(0);
		w(cfg(2), cw(8'h02, 4'h4, 2'b01, 2'b01) | 32'h80000000);
		pulse(2);
		w(dcid_pkg::PCLR_OFF, 32'h4);
		w(cfg(2), cw(8'h02, 4'h4, 2'b01, 2'b01));
		quiet(10);
		w(cfg(16), cw(8'h16, 4'h8, 2'b11, 2'b10));
		@(posedge clk_i) err_irq <= 1'b1;
		pin(1, 1'b1);
		chk({30'h0, cpu_int}, 32'h2);
		@(posedge clk_i) err_irq <= 1'b0;
		pin(1, 1'b0);
	endtask

	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		ext_irq = '0;
		timer_evt = '0;
		err_irq = 1'b0;
		miscompares = 0;
		n_compared = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		s_regs();
		s_edge();
		s_shared();
		s_direct();
		s_mask();
		finish_test();
	end
endmodule
